//--- lfd_core.sv
// Summary of operation
// R1: open bit is 1 when channel voltage exceeds open threshold, else 0.
// R2: open comparator result counts only while channel is driven on.
// R3: open threshold set per red, green, blue group.
// R4: segment end latches 48 open bits and records open line warning.
// R5: controller sets fault readback enable before reading open data.
// R6: controller waits one sub-period between second and third read command.
// R7: with open removal enabled, recorded open channels forced off on their line.
// R8: suppression lasts until reset or open removal enable written 0.
// R9: only first three open lines are held for suppression.
// R10: short bit is 1 when channel voltage below short threshold, else 0.
// R11: short comparator result counts only during channel on period.
// R12: short threshold set per red, green, blue group.
// R13: segment end latches 48 short bits and records short line warning.
// R14: controller sets fault readback enable before reading short data.
// R15: undervoltage or init request enters initialization, resetting all state.
// R16: initialization leaves to normal once undervoltage clears.
// R17: all-zero next frame enters power save at frame sync, channels off.
// R18: non-zero next frame data leaves power save immediately.
// R19: reference short indication turns all channels off until it recovers.
// R20: over-temperature indication turns all channels off until it clears.
// R21: init above protections, protections above power save and normal.
module lfd_core
	import lfd_pkg::*;
#(
	parameter int unsigned N_CH = CHANNELS
) (
	// clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	// supervisory indications
	input  wire logic                 undervoltage_i,
	input  wire logic                 init_request_i,
	input  wire logic                 ref_short_i,
	input  wire logic                 overtemp_i,
	// frame control
	input  wire logic                 frame_sync_i,
	input  wire logic                 next_frame_zero_i,
	input  wire logic                 next_frame_nonzero_i,
	// scan timing
	input  wire logic [LINE_BITS-1:0] scan_line_i,
	input  wire logic                 segment_end_i,
	input  wire logic [N_CH-1:0]      channel_on_i,
	// analog channel levels, threshold codes per group
	input  wire logic [THR_BITS-1:0]  channel_level_i [N_CH],
	input  wire logic [THR_BITS-1:0]  open_threshold_red_i,
	input  wire logic [THR_BITS-1:0]  open_threshold_green_i,
	input  wire logic [THR_BITS-1:0]  open_threshold_blue_i,
	input  wire logic [THR_BITS-1:0]  short_threshold_red_i,
	input  wire logic [THR_BITS-1:0]  short_threshold_green_i,
	input  wire logic [THR_BITS-1:0]  short_threshold_blue_i,
	// control bits
	input  wire logic                 open_removal_enable_i,
	input  wire logic                 fault_readback_enable_i,
	// channel drive
	output logic [N_CH-1:0]           channel_output_o,
	// diagnostics
	output logic [N_CH-1:0]           open_data_o,
	output logic [N_CH-1:0]           short_data_o,
	output logic [LINE_BITS-1:0]      open_line_warning_o,
	output logic [LINE_BITS-1:0]      short_line_warning_o,
	output logic                      open_line_valid_o,
	output logic                      short_line_valid_o,
	output logic [2:0]                mode_o
);

	// operating mode, current and next
	lfd_mode_type               mode;
	lfd_mode_type               next_mode;

	// comparator results of this cycle, already gated by the on period
	logic [N_CH-1:0]            open_now;
	logic [N_CH-1:0]            short_now;

	// segment accumulators and the latched per-channel records
	logic [N_CH-1:0]            open_acc;
	logic [N_CH-1:0]            short_acc;
	logic [N_CH-1:0]            open_reg;
	logic [N_CH-1:0]            short_reg;

	// last faulty line of each kind and whether one was ever seen
	logic [LINE_BITS-1:0]       open_line;
	logic [LINE_BITS-1:0]       short_line;
	logic                       open_seen;
	logic                       short_seen;

	// open removal table: one line number and one channel mask per slot
	logic [LINE_BITS-1:0]       rm_line [RM_SLOTS];
	logic [N_CH-1:0]            rm_mask [RM_SLOTS];
	logic [RM_SLOTS-1:0]        rm_used;

	// derived controls
	logic [N_CH-1:0]            suppress;
	logic                       in_init;
	logic                       clear_all;

	// channel index maps to its colour group: r,g,b repeating
	// the same mapping serves the open and the short thresholds
	function automatic logic [1:0] group_of(input int unsigned ch);
		group_of = 2'(ch % GROUP_COUNT);
	endfunction

	// selects the threshold code of a group; the unused group code falls to blue
	function automatic logic [THR_BITS-1:0] pick(input logic [1:0] g, input logic [THR_BITS-1:0] r,
		input logic [THR_BITS-1:0] gr, input logic [THR_BITS-1:0] b);
		pick = (g == 2'h0) ? r : ((g == 2'h1) ? gr : b);
	endfunction

	// comparators gated by the on period, off-time results are meaningless
	// an off channel floats toward either rail, so without the gate it would
	// report open and short faults at random on every idle channel
	always_comb begin
		for (int unsigned c = 0; c < N_CH; c++) begin
			open_now[c]  = channel_on_i[c] &&                                        // see R2
				(channel_level_i[c] > pick(group_of(c), open_threshold_red_i,
				open_threshold_green_i, open_threshold_blue_i));                    // see R1, see R3
			short_now[c] = channel_on_i[c] &&                                       // see R11
				(channel_level_i[c] < pick(group_of(c), short_threshold_red_i,
				short_threshold_green_i, short_threshold_blue_i));                  // see R10, see R12
		end
	end

	// init mode is the register clear; reset always lands there, so every
	// record is wiped for at least one cycle after reset is released
	// the clear is level based: a held init cause keeps all records empty
	assign in_init   = (mode == lfd_init);
	assign clear_all = in_init;                                                     // see R15

	// mode sequencing with fixed priority: init causes first, then the two
	// protections, then power save and normal
	// a protection seen while leaving init goes straight to its own mode, so
	// the channels never light for a cycle while a protection is asserted
	// power save is entered only on a frame sync, but left at once
	always_comb begin
		next_mode = mode;
		if (undervoltage_i || init_request_i) begin
			next_mode = lfd_init;                                                   // see R15, see R21
		end else if (mode == lfd_init && !overtemp_i && !ref_short_i) begin
			next_mode = lfd_normal;                                                 // see R16
		end else if (overtemp_i) begin
			next_mode = lfd_overtemp;                                               // see R20, see R21
		end else if (ref_short_i) begin
			next_mode = lfd_ref_short;                                              // see R19, see R21
		end else if (mode == lfd_overtemp || mode == lfd_ref_short) begin
			next_mode = lfd_normal;                                                 // protection cleared
		end else if (mode == lfd_power_save) begin
			if (next_frame_nonzero_i) begin
				next_mode = lfd_normal;                                             // see R18
			end
		end else if (frame_sync_i && next_frame_zero_i) begin
			next_mode = lfd_power_save;                                             // see R17
		end
	end

	// mode register; next_mode also feeds the channel drive, so the blanking
	// of the outputs and the reported mode change on the same edge
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode <= lfd_init;
		end else begin
			mode <= next_mode;
		end
	end

	// per-segment accumulation; a fault anywhere in the on time counts
	// the segment end cycle itself is folded in by the latch below, so the
	// accumulator can restart on that edge without losing its last cycle
	// init clears it too, so a segment cut by init reports only what follows the init
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			open_acc  <= FAULT_RESET;
			short_acc <= FAULT_RESET;
		end else if (clear_all || segment_end_i) begin
			open_acc  <= FAULT_RESET;
			short_acc <= FAULT_RESET;
		end else begin
			open_acc  <= open_acc | open_now;
			short_acc <= short_acc | short_now;
		end
	end

	// segment end latches result; the line warning keeps the last faulty line
	// the records hold until the next segment end or init, which gives the
	// controller a whole segment to fetch them through the read-back path
	// init wins over a segment end in the same cycle
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			open_reg   <= FAULT_RESET;
			short_reg  <= FAULT_RESET;
			open_line  <= LINE_RESET;
			short_line <= LINE_RESET;
			open_seen  <= 1'b0;
			short_seen <= 1'b0;
		end else if (clear_all) begin
			open_reg   <= FAULT_RESET;
			short_reg  <= FAULT_RESET;
			open_line  <= LINE_RESET;
			short_line <= LINE_RESET;
			open_seen  <= 1'b0;
			short_seen <= 1'b0;
		end else if (segment_end_i) begin
			open_reg  <= open_acc | open_now;                                       // see R4
			short_reg <= short_acc | short_now;                                     // see R13
			// a clean segment leaves the previous line warning in place
			if (|(open_acc | open_now)) begin
				open_line <= scan_line_i;                                           // see R4
				open_seen <= 1'b1;
			end
			if (|(short_acc | short_now)) begin
				short_line <= scan_line_i;                                          // see R13
				short_seen <= 1'b1;
			end
		end
	end

	// removal table: three slots, filled in detection order, never replaced
	// limitation: opens on a fourth line still cause ghosting on that line
	// clearing the enable empties the table, so re-enabling starts fresh
	// instead of reusing masks that may belong to a repaired matrix
	// the clear wins over a segment end in the same cycle
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rm_used <= '0;
			for (int unsigned s = 0; s < RM_SLOTS; s++) begin
				rm_line[s] <= LINE_RESET;
				rm_mask[s] <= FAULT_RESET;
			end
		end else if (clear_all || !open_removal_enable_i) begin
			rm_used <= '0;                                                          // see R8
			for (int unsigned s = 0; s < RM_SLOTS; s++) begin
				rm_mask[s] <= FAULT_RESET;
			end
		end else if (segment_end_i && |(open_acc | open_now)) begin
			// a line already held gains new channels; a fourth line is dropped
			// matching slots are searched first so one line never takes two slots
			if (rm_used[0] && rm_line[0] == scan_line_i) begin
				rm_mask[0] <= rm_mask[0] | open_acc | open_now;
			end else if (rm_used[1] && rm_line[1] == scan_line_i) begin
				rm_mask[1] <= rm_mask[1] | open_acc | open_now;
			end else if (rm_used[2] && rm_line[2] == scan_line_i) begin
				rm_mask[2] <= rm_mask[2] | open_acc | open_now;
			end else if (!rm_used[0]) begin
				rm_used[0] <= 1'b1;
				rm_line[0] <= scan_line_i;
				rm_mask[0] <= open_acc | open_now;
			end else if (!rm_used[1]) begin
				rm_used[1] <= 1'b1;
				rm_line[1] <= scan_line_i;
				rm_mask[1] <= open_acc | open_now;
			end else if (!rm_used[2]) begin
				rm_used[2] <= 1'b1;
				rm_line[2] <= scan_line_i;
				rm_mask[2] <= open_acc | open_now;                                  // see R9
			end
		end
	end

	// suppression mask for the line being scanned
	// gated by the enable as well, so turning removal off takes effect on
	// the same drive edge that clears the table
	always_comb begin
		suppress = '0;
		for (int unsigned s = 0; s < RM_SLOTS; s++) begin
			if (open_removal_enable_i && rm_used[s] && rm_line[s] == scan_line_i) begin
				suppress = suppress | rm_mask[s];                                   // see R7
			end
		end
	end

	// channel drive registered; any non-normal mode blanks everything
	// blanking is decided from next_mode rather than mode, which costs a
	// longer path from the mode causes but keeps a protection from leaking
	// one lit cycle before the mode register catches up
	// a suppressed channel stays off for the whole scan of its line
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			channel_output_o <= '0;
		end else if (next_mode != lfd_normal) begin
			channel_output_o <= '0;                                                 // see R17, see R19, see R20
		end else begin
			channel_output_o <= channel_on_i & ~suppress;                           // see R7
		end
	end

	// read-back views only show data while read-back is enabled
	// the gate sits after the latches, so detection keeps running and the
	// records are complete the moment read-back is switched on
	// the records themselves are never cleared by the read-back bit
	assign open_data_o          = fault_readback_enable_i ? open_reg : '0;
	assign short_data_o         = fault_readback_enable_i ? short_reg : '0;

	// line records and their flags stay visible regardless of read-back
	assign open_line_warning_o  = open_line;
	assign short_line_warning_o = short_line;
	assign open_line_valid_o    = open_seen;
	assign short_line_valid_o   = short_seen;

	// mode code follows the declaration order of the mode type
	assign mode_o               = mode;

endmodule

//--- lfd_pkg.sv
package lfd_pkg;
	localparam int unsigned CHANNELS    = 48;
	localparam int unsigned LINE_BITS   = 6;
	localparam int unsigned RM_SLOTS    = 3;
	localparam int unsigned GROUP_COUNT = 3;
	localparam int unsigned THR_BITS    = 4;
	// reset values of the latched diagnostics
	localparam logic [47:0] FAULT_RESET = 48'h0000_0000_0000;
	localparam logic [5:0]  LINE_RESET  = 6'h00;
	typedef enum logic [2:0] {
		lfd_init,
		lfd_normal,
		lfd_power_save,
		lfd_ref_short,
		lfd_overtemp
	} lfd_mode_type;
endpackage

//--- lfd_props.sv
module lfd_props
	import lfd_pkg::*;
#(
	parameter int unsigned N_CH = CHANNELS
) (
	// clock, reset, mode causes and read-back enable
	input wire logic            clock_i,
	input wire logic            rst_n_i,
	input wire logic            undervoltage_i,
	input wire logic            init_request_i,
	input wire logic            ref_short_i,
	input wire logic            overtemp_i,
	input wire logic            frame_sync_i,
	input wire logic            next_frame_zero_i,
	input wire logic            next_frame_nonzero_i,
	input wire logic            fault_readback_enable_i,
	// observed outputs
	input wire logic [N_CH-1:0] channel_output_o,
	input wire logic [N_CH-1:0] open_data_o,
	input wire logic [N_CH-1:0] short_data_o,
	input wire logic [2:0]      mode_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic hold_init;
	// init causes outrank everything, so most mode checks exclude them
	assign hold_init = undervoltage_i | init_request_i;
	property p_init; hold_init |=> mode_o == 3'h0; endproperty
	a_init: assert property (p_init) else $error("init mode not entered");
	property p_exit; mode_o == 3'h0 && !hold_init && !ref_short_i && !overtemp_i |=> mode_o == 3'h1; endproperty
	a_exit: assert property (p_exit) else $error("normal mode not reached");
	property p_hot; overtemp_i && !hold_init |=> mode_o == 3'h4; endproperty
	a_hot: assert property (p_hot) else $error("overtemp mode missing");
	property p_ref; ref_short_i && !overtemp_i && !hold_init |=> mode_o == 3'h3; endproperty
	a_ref: assert property (p_ref) else $error("ref short mode missing");
	property p_ps_in; mode_o == 3'h1 && frame_sync_i && next_frame_zero_i && !next_frame_nonzero_i
		&& !hold_init && !ref_short_i && !overtemp_i |=> mode_o == 3'h2; endproperty
	a_ps_in: assert property (p_ps_in) else $error("power save not entered");
	property p_ps_out; mode_o == 3'h2 && next_frame_nonzero_i && !hold_init && !ref_short_i && !overtemp_i
		|=> mode_o == 3'h1; endproperty
	a_ps_out: assert property (p_ps_out) else $error("power save not left");
	property p_blank; mode_o != 3'h1 |-> channel_output_o == '0; endproperty
	a_blank: assert property (p_blank) else $error("channel driven outside normal");
	property p_gate; !fault_readback_enable_i |-> open_data_o == '0 && short_data_o == '0; endproperty
	a_gate: assert property (p_gate) else $error("fault data visible while readback off");
endmodule

bind lfd_core lfd_props #(.N_CH(N_CH)) props (.clock_i, .rst_n_i, .undervoltage_i, .init_request_i, .ref_short_i,
	.overtemp_i, .frame_sync_i, .next_frame_zero_i, .next_frame_nonzero_i, .fault_readback_enable_i,
	.channel_output_o, .open_data_o, .short_data_o, .mode_o);

//--- lfd_matrix.sv
module lfd_matrix
	import lfd_pkg::*;
(
	// clock and channel drive
	input  wire logic [0:0]          clock_i,
	input  wire logic [CHANNELS-1:0] channel_on_i,
	// injected faults
	input  wire logic [CHANNELS-1:0] open_mask_i,
	input  wire logic [CHANNELS-1:0] short_mask_i,
	// sensed voltage codes
	output logic [THR_BITS-1:0]      channel_level_o [CHANNELS]
);
	timeunit 1ns;
	timeprecision 1ps;
	logic toggle = 1'b0;
	// an off channel floats, so its reading swings rail to rail every cycle
	always @(posedge clock_i) toggle <= ~toggle;
	// open pulls the pin high, short pulls it low, a healthy led sits mid-range
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (!channel_on_i[c]) channel_level_o[c] = {THR_BITS{toggle}};
			else channel_level_o[c] = open_mask_i[c] ? 4'hF : short_mask_i[c] ? 4'h0 : 4'h8;
		end
	end
endmodule

//--- tb.sv
module tb
	import lfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0, rst_n_i = 1'b0, segment_end_i = 1'b0, frame_sync_i = 1'b0;
	logic        undervoltage_i = 1'b0, init_request_i = 1'b0, ref_short_i = 1'b0, overtemp_i = 1'b0;
	logic        next_frame_zero_i = 1'b0, next_frame_nonzero_i = 1'b0;
	logic        open_removal_enable_i = 1'b0, fault_readback_enable_i = 1'b1;
	logic [5:0]  scan_line_i = 6'h00, open_line_warning_o, short_line_warning_o, oline = 6'h00, sline = 6'h00;
	logic [47:0] channel_on_i = '0, open_mask = '0, short_mask = '0, channel_output_o, open_data_o, short_data_o;
	logic [3:0]  othr [3] = '{3{4'h0}}, sthr [3] = '{3{4'h0}}, channel_level_i [48];
	logic [2:0]  mode_o;
	logic [5:0]  lines [4] = '{6'h05, 6'h09, 6'h0C, 6'h14};
	// uv, init, ref short, overtemp, sync, zero, nonzero, then expected mode
	logic [9:0]  modes [14] = '{10'h0C4, 10'h083, 10'h001, 10'h032, 10'h012, 10'h009, 10'h074, 10'h001,
		10'h100, 10'h240, 10'h001, 10'h100, 10'h044, 10'h001};
	logic        open_line_valid_o, short_line_valid_o, ov = 1'b0, sv = 1'b0;
	int          mismatches = 0, comparisons = 0, seed = 96012;

	lfd_matrix model (.clock_i, .channel_on_i, .open_mask_i(open_mask), .short_mask_i(short_mask),
		.channel_level_o(channel_level_i));
	lfd_core uut (.clock_i, .rst_n_i, .undervoltage_i, .init_request_i, .ref_short_i, .overtemp_i, .frame_sync_i,
		.next_frame_zero_i, .next_frame_nonzero_i, .scan_line_i, .segment_end_i, .channel_on_i, .channel_level_i,
		.open_threshold_red_i(othr[0]), .open_threshold_green_i(othr[1]), .open_threshold_blue_i(othr[2]),
		.short_threshold_red_i(sthr[0]), .short_threshold_green_i(sthr[1]), .short_threshold_blue_i(sthr[2]),
		.open_removal_enable_i, .fault_readback_enable_i, .channel_output_o, .open_data_o, .short_data_o,
		.open_line_warning_o, .short_line_warning_o, .open_line_valid_o, .short_line_valid_o, .mode_o);

	// 40 MHz clock
	initial begin
		forever #12.5 clock_i = ~clock_i;
	end

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize;
		if (mismatches == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// channel c belongs to colour group c % 3; off channels never count
	function automatic logic [47:0] want(input bit shrt);
		logic [3:0] lv;
		for (int c = 0; c < 48; c++) begin
			lv = open_mask[c] ? 4'hF : short_mask[c] ? 4'h0 : 4'h8;
			want[c] = channel_on_i[c] & (shrt ? lv < sthr[c % 3] : lv > othr[c % 3]);
		end
	endfunction

	// one four-cycle segment on a line; drive is checked before the latch
	task automatic segment(input logic [5:0] line, input logic [47:0] on, input logic [47:0] drive);
		logic [47:0] o, s;
		scan_line_i = line;
		channel_on_i = on;
		@(negedge clock_i);
		check("channel drive", channel_output_o, drive);
		repeat (2) @(negedge clock_i);
		segment_end_i = 1'b1;
		@(negedge clock_i);
		segment_end_i = 1'b0;
		o = want(1'b0);
		s = want(1'b1);
		if (|o) oline = line;
		if (|s) sline = line;
		ov = ov | (|o);
		sv = sv | (|s);
		// read one whole segment after read-back was set
		check("open data", open_data_o, fault_readback_enable_i ? o : '0);
		check("short data", short_data_o, fault_readback_enable_i ? s : '0);
		check("open line", 48'(open_line_warning_o), 48'(oline));
		check("short line", 48'(short_line_warning_o), 48'(sline));
		check("line valid", 48'({open_line_valid_o, short_line_valid_o}), 48'({ov, sv}));
	endtask

	initial begin
		logic [47:0] on;
		repeat (2) @(negedge clock_i);
		rst_n_i = 1'b1;
		@(negedge clock_i);
		// random faults, thresholds, readback and drive patterns
		for (int i = 0; i < 16; i++) begin
			open_mask = 48'({$random(seed), $random(seed)});
			short_mask = 48'({$random(seed), $random(seed)}) & ~open_mask;
			for (int g = 0; g < 3; g++) begin
				othr[g] = 4'($random(seed));
				sthr[g] = 4'($random(seed));
			end
			fault_readback_enable_i = 1'($random(seed));
			on = 48'({$random(seed), $random(seed)});
			segment(6'($random(seed)), on, on);
		end
		// removal: four faulty lines, only the first three get suppressed
		open_mask = 48'h0000_0000_0F0F;
		short_mask = '0;
		othr = '{3{4'h9}};
		fault_readback_enable_i = 1'b1;
		open_removal_enable_i = 1'b1;
		foreach (lines[k]) segment(lines[k], '1, '1);
		foreach (lines[k]) segment(lines[k], '1, k < 3 ? ~open_mask : '1);
		open_removal_enable_i = 1'b0;
		@(negedge clock_i);
		segment(lines[0], '1, '1);
		// re-enabling starts from an empty table, so nothing is suppressed yet
		open_removal_enable_i = 1'b1;
		segment(lines[1], '1, '1);
		open_removal_enable_i = 1'b0;
		// mode sequencing and blanking, one cycle per table row
		foreach (modes[k]) begin
			{undervoltage_i, init_request_i, ref_short_i, overtemp_i, frame_sync_i, next_frame_zero_i,
				next_frame_nonzero_i} = modes[k][9:3];
			@(negedge clock_i);
			check("mode", 48'(mode_o), 48'(modes[k][2:0]));
			check("blanking", channel_output_o, modes[k][2:0] == 3'h1 ? '1 : '0);
		end
		check("init clears data", open_data_o, '0);
		check("init clears flags", 48'({open_line_valid_o, short_line_valid_o, open_line_warning_o}), 48'h0);
		summarize;
	end
endmodule
